// >>> alu_core.v
`timescale 1ns/100ps
`include "cpu_slice_defines.vh"

// ==========================================================
// byte alu for compare, complement, decimal adjust, decrement
module alu_core (
  // operation
  input  wire [1:0] op,
  input  wire       use_carry,
  // operands and flags in
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       c_in,
  input  wire       d_in,
  input  wire       h_in,
  // result
  output reg  [7:0] res,
  output reg        c_out,
  output reg        v_out
);

  reg [8:0] diff;
  reg       lo_adj;
  reg       hi_adj;

  always @* begin
    diff   = {1'b0, a} - {1'b0, b} - {8'h00, use_carry & c_in}; // see RQ5
    lo_adj = h_in | (~d_in & (a[3:0] > 4'h9));
    hi_adj = c_in | (~d_in & (a > 8'h99));
    res    = diff[7:0];
    c_out  = diff[8];
    v_out  = (a[7] ^ b[7]) & (diff[7] ^ a[7]); // see RQ4
    case (op)
      `ALU_COM: begin
        res   = ~a; // see RQ3
        c_out = c_in;
        v_out = 1'b0;
      end
      `ALU_DA: begin
        // after a subtraction the correction is taken away, else added
        if (d_in) begin
          res = a - {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0}; // see RQ7
        end else begin
          res = a + {hi_adj ? 4'h6 : 4'h0, lo_adj ? 4'h6 : 4'h0};
        end
        c_out = hi_adj;
        v_out = 1'b0;
      end
      `ALU_DEC: begin
        res   = a - 8'h01; // see RQ8
        c_out = c_in;
        v_out = (a == 8'h80);
      end
      default: begin
        res   = diff[7:0];
      end
    endcase
  end

endmodule // alu_core

// >>> cpu_compare_decrement_decode_tb_top.sv
`timescale 1ns/100ps
`include "cpu_slice_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
// ==========
// bench top
module cpu_compare_decrement_decode_tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pm_addr;
  logic        pm_rd;
  logic [7:0]  pm_data;
  logic        busy;
  int          errors = 0;
  int          cmp_count = 0;

  always #25 pclk = ~pclk;

  cpu_slice i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .busy(busy));
  prog_mem i_mem (.pclk(pclk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));

  // ==========
  // bus tasks
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never gets an answer
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task set_rf(input logic [7:0] a, input logic [7:0] d);
    wr(`OFS_RF_ADDR, {24'h0, a});
    wr(`OFS_RF_DATA, {24'h0, d});
  endtask
  task get_rf(input logic [7:0] a, output logic [31:0] q);
    wr(`OFS_RF_ADDR, {24'h0, a});
    rd(`OFS_RF_DATA, q);
  endtask
  // runs code from address 0 until the filler byte stops it, returns flags
  task run(input logic [31:0] c, input logic [7:0] f, output logic [31:0] q);
    int n;
    begin
      {i_mem.mem[0], i_mem.mem[1], i_mem.mem[2], i_mem.mem[3]} = c;
      wr(`OFS_FLAGS, {24'h0, f});
      wr(`OFS_PC, 32'h0);
      wr(`OFS_CTRL, 32'h1);
      n = 0;
      do begin
        rd(`OFS_STATUS, q);
        n++;
      end while (q[1] !== 1'b1 && n < 60);
      `CHK(q[1], 1'b1)
      wr(`OFS_STATUS, 32'h2);
      rd(`OFS_STATUS, q);
      `CHK({q[1:0], busy}, 3'b000)
      rd(`OFS_FLAGS, q);
    end
  endtask

  // ==========
  // scenarios
  task t_cp;
    logic [31:0] q;
    logic e;
    begin
      apb(1'b0, 8'h22, 32'h0, q, e);
      `CHK({e, q}, 33'h1_0000_0000)
      set_rf(8'h43, 8'h10);
      set_rf(8'h08, 8'h20);
      run(32'ha40843ff, 8'h00, q);
      `CHK(q[7:0], 8'ha0)
      get_rf(8'h43, q);
      `CHK(q[7:0], 8'h10)
      $display("compare done");
    end
  endtask
  task t_cpc;
    logic [31:0] q;
    begin
      wr(`OFS_WBASE, 32'h30);
      set_rf(8'h38, 8'h1f);
      set_rf(8'he8, 8'h00);
      set_rf(8'h43, 8'h20);
      run(32'h1fa4e843, 8'hc0, q);
      `CHK(q[7:0], 8'h40)
      run(32'ha9550043, 8'h00, q);
      `CHK(q[7:0], 8'ha0)
      $display("carry and escaped compare done");
    end
  endtask
  task t_modes;
    logic [31:0] q;
    begin
      wr(`OFS_WBASE, 32'h40);
      set_rf(8'h42, 8'h01);
      set_rf(8'h43, 8'h80);
      set_rf(8'h44, 8'h42);
      run(32'ha232ffff, 8'h00, q);
      `CHK(q[7:0], 8'h10)
      run(32'ha54443ff, 8'h00, q);
      `CHK(q[7:0], 8'h10)
      run(32'ha8042443, 8'h00, q);
      `CHK(q[7:0], 8'h10)
      run(32'h8144ffff, 8'h00, q);
      `CHK(q[7:0], 8'h00)
      get_rf(8'h43, q);
      `CHK(q[7:0], 8'h7f)
      get_rf(8'h42, q);
      `CHK(q[7:0], 8'h01)
      $display("addressing modes done");
    end
  endtask
  task t_unary(input logic [31:0] c, input logic [7:0] d, input logic [7:0] f,
               input logic [15:0] exp);
    logic [31:0] q;
    begin
      set_rf(8'h43, d);
      run(c, f, q);
      `CHK(q[7:0], exp[7:0])
      get_rf(8'h43, q);
      `CHK(q[7:0], exp[15:8])
      $display("single operand op done");
    end
  endtask
  task t_word_decrement_op;
    logic [31:0] q;
    begin
      set_rf(8'h42, 8'h01);
      set_rf(8'h43, 8'h00);
      run(32'h8042ffff, 8'h80, q);
      `CHK(q[7:0], 8'h80)
      get_rf(8'h42, q);
      `CHK(q[7:0], 8'h00)
      get_rf(8'h43, q);
      `CHK(q[7:0], 8'hff)
      $display("word decrement done");
    end
  endtask
  task t_di_decrement_branch_op;
    logic [31:0] q;
    begin
      rd(`OFS_INTERRUPT_CONTROL_REG, q);
      `CHK(q, 32'h0)
      wr(`OFS_INTERRUPT_CONTROL_REG, 32'hff);
      run(32'h8fffffff, 8'h44, q);
      `CHK(q[7:0], 8'h44)
      rd(`OFS_INTERRUPT_CONTROL_REG, q);
      `CHK(q, 32'h7f)
      wr(`OFS_WBASE, 32'h30);
      set_rf(8'h31, 8'h03);
      run(32'h1afeffff, 8'h00, q);
      `CHK(q[7:0], 8'h00)
      get_rf(8'h31, q);
      `CHK(q[7:0], 8'h00)
      $display("interrupt off and loop done");
    end
  endtask

  // ==========
  // sequence and verdict
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_cp;
    t_cpc;
    t_modes;
    t_unary(32'h6043ffff, 8'h0f, 8'h94, 16'hf0a4);
    t_unary(32'h4043ffff, 8'h1a, 8'h00, 16'h2000);
    t_unary(32'h3043ffff, 8'h80, 8'h80, 16'h7f90);
    t_word_decrement_op;
    t_di_decrement_branch_op;
    close_out;
  end
  // whole run needs a few hundred cycles; twenty thousand means a hang
  initial begin
    #(50 * 20000);
    errors++;
    close_out;
  end
endmodule // cpu_compare_decrement_decode_tb_top

// >>> cpu_slice.v
// Summary of operation
// RQ1 - source operand byte precedes destination byte
// RQ2 - register operand reaches 0-255 or R0-R15
// RQ3 - complement 60/61 inverts, flags Z S, V=0
// RQ4 - compare A2-A7 subtracts, no store, flags
// RQ5 - prefix 1F compare subtracts carry too
// RQ6 - extended compare A8/A9, prefixed carry variants
// RQ7 - decimal adjust 40/41 corrects packed BCD
// RQ8 - decrement 30/31, carry unchanged
// RQ9 - word decrement 80/81, five/six cycles
// RQ10 - 8F clears interrupt enable bit seven
// RQ11 - xA decrements working reg, branches nonzero
// RQ12 - nibble E escapes to working register
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "cpu_slice_defines.vh"

module cpu_slice (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // program memory, combinational read in the strobe cycle
  output reg  [15:0] pm_addr,
  output reg         pm_rd,
  input  wire [7:0]  pm_data,
  // status
  output reg         busy
);

  // ==========================================================
  // state
  localparam S_IDLE  = 2'd0;
  localparam S_FETCH = 2'd1;
  localparam S_CAPT  = 2'd2;
  localparam S_EXEC  = 2'd3;

  reg [1:0]  state_q;
  reg [15:0] pc_q;
  reg [7:0]  flags_q;
  reg [7:0]  wbase_q;
  reg [7:0]  interrupt_control_reg;
  reg [7:0]  rf_addr_q;
  reg        run_q;
  reg        illegal_q;
  reg        prefix_q;
  reg [7:0]  opc_q;
  reg [7:0]  b1_q;
  reg [7:0]  b2_q;
  reg [7:0]  b3_q;
  reg [1:0]  idx_q;
  reg [1:0]  need_q;
  reg [2:0]  cnt_q;
  reg [7:0]  rf [0:255];

  // ==========================================================
  // operand decode
  wire [7:0] m1;
  wire [7:0] m2;
  wire [7:0] w_hi = {wbase_q[7:4], b1_q[7:4]};
  wire [7:0] w_lo = {wbase_q[7:4], b1_q[3:0]};
  wire [7:0] ind1 = rf[m1];
  wire       is_decrement_branch_op = (opc_q[3:0] == `OPC_DECREMENT_BRANCH_OP_LO);

  reg_addr_map u_map1 (
    .raw_addr (b1_q),
    .wbase    (wbase_q),
    .abs_addr (m1)
  );

  reg_addr_map u_map2 (
    .raw_addr (b2_q),
    .wbase    (wbase_q),
    .abs_addr (m2)
  );

  reg [7:0] dst_a;
  reg [7:0] src_v;
  reg [1:0] alu_op;
  reg       do_store;

  always @* begin
    dst_a    = m1;
    src_v    = 8'h00;
    alu_op   = `ALU_SUB;
    do_store = 1'b0;
    if (is_decrement_branch_op) begin
      dst_a = {wbase_q[7:4], opc_q[7:4]}; // see RQ11
      alu_op = `ALU_DEC;
    end else begin
      case (opc_q)
        `OPC_COM_R:     begin alu_op = `ALU_COM; do_store = 1'b1; end
        `OPC_COM_IR:    begin alu_op = `ALU_COM; do_store = 1'b1; dst_a = ind1; end
        `OPC_DA_R:      begin alu_op = `ALU_DA;  do_store = 1'b1; end
        `OPC_DA_IR:     begin alu_op = `ALU_DA;  do_store = 1'b1; dst_a = ind1; end
        `OPC_DEC_R:     begin alu_op = `ALU_DEC; do_store = 1'b1; end
        `OPC_DEC_IR:    begin alu_op = `ALU_DEC; do_store = 1'b1; dst_a = ind1; end
        `OPC_WORD_DECREMENT_OP_IRR:  dst_a = ind1;
        `OPC_CP_RR_W:   begin dst_a = w_hi; src_v = rf[w_lo]; end // see RQ4
        `OPC_CP_R_IRW:  begin dst_a = w_hi; src_v = rf[rf[w_lo]]; end
        // source byte comes first, destination second
        `OPC_CP_R_R:    begin dst_a = m2; src_v = ind1; end // see RQ1
        `OPC_CP_R_IR:   begin dst_a = m2; src_v = rf[ind1]; end
        `OPC_CP_R_IM:   src_v = b2_q;
        `OPC_CP_IR_IM:  begin dst_a = ind1; src_v = b2_q; end
        // only the low byte of a 12-bit extended address is decoded
        `OPC_CPX_ER_ER: begin dst_a = b3_q; src_v = rf[{b1_q[3:0], b2_q[7:4]}]; end // see RQ6
        `OPC_CPX_ER_IM: begin dst_a = b3_q; src_v = b1_q; end
        default:        dst_a = m1;
      endcase
    end
  end

  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_v;

  alu_core u_alu (
    .op        (alu_op),
    .use_carry (prefix_q),
    .a         (rf[dst_a]),
    .b         (src_v),
    .c_in      (flags_q[`FLAG_C]),
    .d_in      (flags_q[`FLAG_D]),
    .h_in      (flags_q[`FLAG_H]),
    .res       (alu_res),
    .c_out     (alu_c),
    .v_out     (alu_v)
  );

  // word decrement on an even-aligned pair, high byte first
  wire [7:0]  pair_a  = {dst_a[7:1], 1'b0};
  wire [7:0]  pair_b  = {dst_a[7:1], 1'b1};
  wire [15:0] word_in = {rf[pair_a], rf[pair_b]};
  wire [15:0] word_rs = word_in - 16'h0001; // see RQ9
  wire        is_word = (opc_q == `OPC_WORD_DECREMENT_OP_RR) || (opc_q == `OPC_WORD_DECREMENT_OP_IRR);

  // ==========================================================
  // opcode tables: bytes after the opcode, execute cycles
  reg [1:0] len_d;
  reg       legal_d;
  reg [2:0] exc_d;

  always @* begin
    len_d   = 2'd1;
    legal_d = 1'b1;
    exc_d   = `EXC_3;
    if (pm_data[3:0] == `OPC_DECREMENT_BRANCH_OP_LO && !prefix_q) begin
      len_d = 2'd1;
    end else begin
      case (pm_data)
        `OPC_COM_R, `OPC_DA_R, `OPC_DEC_R:    exc_d = `EXC_2;
        `OPC_COM_IR, `OPC_DA_IR, `OPC_DEC_IR: exc_d = `EXC_3;
        `OPC_WORD_DECREMENT_OP_RR:   exc_d = `EXC_5; // see RQ9
        `OPC_WORD_DECREMENT_OP_IRR:  exc_d = `EXC_6;
        `OPC_DI: begin
          len_d = 2'd0; // see RQ10
          exc_d = `EXC_2;
        end
        `OPC_CP_RR_W:   exc_d = `EXC_3;
        `OPC_CP_R_IRW:  exc_d = `EXC_4;
        `OPC_CP_R_R, `OPC_CP_R_IM: begin
          len_d = 2'd2;
          exc_d = `EXC_3;
        end
        `OPC_CP_R_IR, `OPC_CP_IR_IM: begin
          len_d = 2'd2;
          exc_d = `EXC_4;
        end
        `OPC_CPX_ER_ER, `OPC_CPX_ER_IM: begin
          len_d = 2'd3; // see RQ6
          exc_d = `EXC_3;
        end
        default: legal_d = 1'b0;
      endcase
    end
    // the prefix only combines with the compare family
    if (prefix_q && (pm_data < `OPC_CP_RR_W || pm_data > `OPC_CPX_ER_IM)) begin
      legal_d = 1'b0; // see RQ5
    end
    if (!prefix_q && pm_data[3:0] == `OPC_DECREMENT_BRANCH_OP_LO) begin
      exc_d = `EXC_3;
    end
  end

  // ==========================================================
  // apb decode
  wire        apb_wr = psel & penable & pready & pwrite;
  wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_FLAGS);
  reg  [31:0] rd_d;

  always @* begin
    case (paddr)
      `OFS_CTRL:    rd_d = {31'h0, run_q};
      `OFS_STATUS:  rd_d = {16'h0, flags_q, 6'h00, illegal_q, busy};
      `OFS_PC:      rd_d = {16'h0, pc_q};
      `OFS_WBASE:   rd_d = {24'h0, wbase_q};
      `OFS_INTERRUPT_CONTROL_REG:  rd_d = {24'h0, interrupt_control_reg};
      `OFS_RF_ADDR: rd_d = {24'h0, rf_addr_q};
      `OFS_RF_DATA: rd_d = {24'h0, rf[rf_addr_q]};
      `OFS_FLAGS:   rd_d = {24'h0, flags_q};
      default:      rd_d = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // sequencer
  wire exec_done = (state_q == S_EXEC) && (cnt_q == 3'd1);
  wire hw_halt   = (state_q == S_CAPT) && (idx_q == 2'd0) && !legal_d &&
                   !(pm_data == `OPC_PREFIX && !prefix_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q               <= S_IDLE;
      pc_q                  <= `RST_PC;
      flags_q               <= `RST_FLAGS;
      wbase_q               <= `RST_WBASE;
      interrupt_control_reg <= `RST_INTERRUPT_CONTROL_REG;
      rf_addr_q             <= 8'h00;
      run_q                 <= 1'b0;
      illegal_q             <= 1'b0;
      prefix_q              <= 1'b0;
      opc_q                 <= 8'h00;
      b1_q                  <= 8'h00;
      b2_q                  <= 8'h00;
      b3_q                  <= 8'h00;
      idx_q                 <= 2'd0;
      need_q                <= 2'd0;
      cnt_q                 <= 3'd0;
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      pm_addr               <= 16'h0000;
      pm_rd                 <= 1'b0;
      busy                  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable) begin
        prdata <= rd_d;
      end
      pm_rd <= 1'b0;
      busy  <= (state_q != S_IDLE) || run_q;
      // software writes first so hardware updates in the same cycle win
      if (apb_wr && mapped) begin
        case (paddr)
          `OFS_CTRL:    run_q <= pwdata[`CTRL_RUN];
          `OFS_STATUS:  if (pwdata[`STAT_ILLEGAL]) illegal_q <= 1'b0;
          `OFS_PC:      pc_q <= pwdata[15:0];
          `OFS_WBASE:   wbase_q <= pwdata[7:0];
          `OFS_INTERRUPT_CONTROL_REG:  interrupt_control_reg <= pwdata[7:0];
          `OFS_RF_ADDR: rf_addr_q <= pwdata[7:0];
          `OFS_RF_DATA: rf[rf_addr_q] <= pwdata[7:0];
          `OFS_FLAGS:   flags_q <= pwdata[7:0];
          default:      run_q <= run_q;
        endcase
      end
      case (state_q)
        S_IDLE: begin
          if (run_q) begin
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          pm_addr <= pc_q;
          pm_rd   <= 1'b1;
          state_q <= S_CAPT;
        end
        S_CAPT: begin
          pc_q <= pc_q + 16'h0001;
          if (idx_q == 2'd0) begin
            if (pm_data == `OPC_PREFIX && !prefix_q) begin
              prefix_q <= 1'b1; // see RQ5
              state_q  <= S_FETCH;
            end else if (hw_halt) begin
              illegal_q <= 1'b1;
              run_q     <= 1'b0;
              prefix_q  <= 1'b0;
              state_q   <= S_IDLE;
            end else begin
              opc_q  <= pm_data;
              need_q <= len_d;
              cnt_q  <= exc_d;
              idx_q  <= 2'd1;
              state_q <= (len_d == 2'd0) ? S_EXEC : S_FETCH;
            end
          end else begin
            case (idx_q)
              2'd1:    b1_q <= pm_data;
              2'd2:    b2_q <= pm_data;
              default: b3_q <= pm_data;
            endcase
            idx_q   <= idx_q + 2'd1;
            state_q <= (idx_q == need_q) ? S_EXEC : S_FETCH;
          end
        end
        default: begin
          cnt_q <= cnt_q - 3'd1;
          if (exec_done) begin
            idx_q    <= 2'd0;
            prefix_q <= 1'b0;
            state_q  <= run_q ? S_FETCH : S_IDLE;
            if (opc_q == `OPC_DI) begin
              interrupt_control_reg[`IRQ_ENABLE_BIT] <= 1'b0; // see RQ10
            end else if (is_decrement_branch_op) begin
              rf[dst_a] <= alu_res; // see RQ11
              if (alu_res != 8'h00) begin
                pc_q <= pc_q + {{8{b1_q[7]}}, b1_q};
              end
            end else if (is_word) begin
              rf[pair_a] <= word_rs[15:8]; // see RQ9
              rf[pair_b] <= word_rs[7:0];
              flags_q[`FLAG_Z] <= (word_rs == 16'h0000);
              flags_q[`FLAG_S] <= word_rs[15];
              flags_q[`FLAG_V] <= (word_in == 16'h8000);
            end else begin
              if (do_store) begin
                rf[dst_a] <= alu_res;
              end
              flags_q[`FLAG_Z] <= (alu_res == 8'h00); // see RQ3 see RQ7 see RQ8
              flags_q[`FLAG_S] <= alu_res[7];
              flags_q[`FLAG_C] <= alu_c; // see RQ4
              if (alu_op != `ALU_DA) begin
                flags_q[`FLAG_V] <= alu_v;
              end
            end
          end
        end
      endcase
    end
  end

endmodule // cpu_slice

// >>> cpu_slice_chk.sv
`timescale 1ns/100ps
`include "cpu_slice_defines.vh"
// ==========
// port checker
module cpu_slice_chk (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // program memory
  input wire [15:0] pm_addr,
  input wire        pm_rd,
  input wire [7:0]  pm_data,
  // status
  input wire        busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire bad = paddr > `OFS_FLAGS || paddr[1:0] != 2'b00;
  property p_ans; psel && !penable |=> pready; endproperty
  property p_acc; pready |-> psel && penable && !$past(penable); endproperty
  property p_err; pready && bad |-> pslverr; endproperty
  property p_ok; pready && !bad |-> !pslverr; endproperty
  property p_rz; pready && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  property p_up; pready && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
  property p_gap; pm_rd |=> !pm_rd; endproperty
  property p_hold; !pm_rd |-> $stable(pm_addr); endproperty
  property p_busy; pm_rd |-> busy; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  a_acc: assert property (p_acc) else $error("ready outside access");
  a_err: assert property (p_err) else $error("bad address accepted");
  a_ok: assert property (p_ok) else $error("good address refused");
  a_rz: assert property (p_rz) else $error("refused read not zero");
  a_up: assert property (p_up) else $error("upper read bits set");
  a_gap: assert property (p_gap) else $error("fetches too close");
  a_hold: assert property (p_hold) else $error("fetch address moved");
  a_busy: assert property (p_busy) else $error("fetch while idle");
  c_err: cover property (pready && pslverr);
  c_run: cover property (pm_rd ##[2:8] pm_rd);
  c_stop: cover property ($fell(busy));
endmodule // cpu_slice_chk

bind cpu_slice cpu_slice_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pm_addr(pm_addr), .pm_rd(pm_rd),
  .pm_data(pm_data), .busy(busy));

// >>> cpu_slice_defines.vh
`ifndef CPU_SLICE_DEFINES_VH
`define CPU_SLICE_DEFINES_VH

// ==========================================================
// apb register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_PC          8'h08
`define OFS_WBASE       8'h0c
`define OFS_INTERRUPT_CONTROL_REG      8'h10
`define OFS_RF_ADDR     8'h14
`define OFS_RF_DATA     8'h18
`define OFS_FLAGS       8'h1c

// ==========================================================
// field positions and reset values
`define CTRL_RUN        0
`define STAT_BUSY       0
`define STAT_ILLEGAL    1
`define IRQ_ENABLE_BIT  7
`define FLAG_C          7
`define FLAG_Z          6
`define FLAG_S          5
`define FLAG_V          4
`define FLAG_D          3
`define FLAG_H          2
`define RST_PC          16'h0000
`define RST_FLAGS       8'h00
`define RST_WBASE       8'h00
`define RST_INTERRUPT_CONTROL_REG      8'h00

// ==========================================================
// opcodes
`define OPC_PREFIX      8'h1f
`define OPC_COM_R       8'h60
`define OPC_COM_IR      8'h61
`define OPC_CP_RR_W     8'ha2
`define OPC_CP_R_IRW    8'ha3
`define OPC_CP_R_R      8'ha4
`define OPC_CP_R_IR     8'ha5
`define OPC_CP_R_IM     8'ha6
`define OPC_CP_IR_IM    8'ha7
`define OPC_CPX_ER_ER   8'ha8
`define OPC_CPX_ER_IM   8'ha9
`define OPC_DA_R        8'h40
`define OPC_DA_IR       8'h41
`define OPC_DEC_R       8'h30
`define OPC_DEC_IR      8'h31
`define OPC_WORD_DECREMENT_OP_RR     8'h80
`define OPC_WORD_DECREMENT_OP_IRR    8'h81
`define OPC_DI          8'h8f
`define OPC_DECREMENT_BRANCH_OP_LO     4'ha
`define ESCAPE_NIBBLE   4'he

// ==========================================================
// alu operations
`define ALU_SUB         2'd0
`define ALU_COM         2'd1
`define ALU_DA          2'd2
`define ALU_DEC         2'd3

// ==========================================================
// execute cycle counts
`define EXC_2           3'd2
`define EXC_3           3'd3
`define EXC_4           3'd4
`define EXC_5           3'd5
`define EXC_6           3'd6

`endif

// >>> prog_mem.sv
`timescale 1ns/100ps
// ==========
// program memory, combinational read of the addressed byte; pclk is not used
module prog_mem (
  // fetch port
  input wire         pclk,
  input wire         pm_rd,
  input wire [15:0]  pm_addr,
  output logic [7:0] pm_data
);
  logic [7:0] mem [0:255];
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // byte stands only in the strobe cycle; the inverse elsewhere exposes a late capture
  always_comb begin
    pm_data = pm_rd ? mem[pm_addr[7:0]] : ~mem[pm_addr[7:0]];
  end
endmodule // prog_mem

// >>> reg_addr_map.v
`timescale 1ns/100ps
`include "cpu_slice_defines.vh"

// ==========================================================
// escaped register address to absolute register address
module reg_addr_map (
  // address in
  input  wire [7:0] raw_addr,
  input  wire [7:0] wbase,
  // address out
  output wire [7:0] abs_addr
);

  // upper nibble 1110 selects a working register off the base
  assign abs_addr = (raw_addr[7:4] == `ESCAPE_NIBBLE) ?
                    {wbase[7:4], raw_addr[3:0]} : raw_addr; // see RQ2 see RQ12

endmodule // reg_addr_map
